//--- rtl/nipc_pkg.sv
// Package for the nested interrupt priority controller.
// Assumes a single 100 MHz clock domain shared with the CPU core and peripherals.
package nipc_pkg;
    localparam int NSRC = 14;
    localparam int ADDR_W = 8;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [ADDR_W-1:0] OFF_PRIO0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PRIO1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PRIO2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRIO3 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    // Field positions
    localparam int CC_LVL_HI_POS = 5;
    localparam int CC_LVL_LO_POS = 3;
    localparam int ST_HALT_POS = 8;
    localparam int ST_BUSY_POS = 9;
    localparam int ST_VNUM_POS = 12;
    // Reset values
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [3:0] PRIO3_RO_ONES = 4'hf;
    localparam logic [1:0] LVL_RST = 2'b11;
    // Level patterns
    localparam logic [1:0] PAT_LVL0 = 2'b10;
    localparam logic [1:0] PAT_LVL1 = 2'b01;
    localparam logic [1:0] PAT_LVL2 = 2'b00;
    localparam logic [1:0] PAT_LVL3 = 2'b11;
    // Vectors
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_SRC0 = 16'hfffa;
    localparam logic [3:0] NUM_TRAP = 4'he;
    localparam logic [3:0] NUM_RESET = 4'hf;
    // Sources able to leave halt; bit 1 only from active halt, bit 3 excludes the voltage detector
    localparam logic [NSRC-1:0] WAKE_MASK = 14'h21bf;
    localparam logic [1:0] PUSH_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        OP_NONE, OP_RIM, OP_SIM, OP_HALT, OP_WFI, OP_IRQ_RETURN_INSTR, OP_POPCC, OP_PUSHCC, OP_TRAP
    } nipc_op_t;

    typedef struct packed {
        logic op_valid;
        nipc_op_t op;
        logic [7:0] cc_in;
        logic boundary;
    } nipc_cpu_req_t;

    typedef struct packed {
        logic push_valid;
        logic [1:0] push_sel;
        logic vec_valid;
        logic [15:0] vec_addr;
        logic [3:0] vec_num;
        logic wake;
    } nipc_entry_t;
endpackage

//--- rtl/nipc_top.sv
// Nested interrupt priority controller: current level, priority registers, arbitration,
// entry sequencing and AXI4-Lite register access.
// Assumes CPU core and peripheral requests come from logic on aclk; requests are levels
// held until the peripheral clears them.
//
// Notes on behaviour
// RULE_01: Current level lives at condition code bits 5 (high) and 3 (low).
// RULE_02: Patterns 10,01,00,11 are levels 0,1,2,3; level 3 disables interrupts.
// RULE_03: Top-level pin, trap and reset still preempt level 3 code.
// RULE_04: Maskable entry loads the level from that vector's priority pair.
// RULE_05: Enable, disable, halt, wait, return, push and pop instructions touch the level; push leaves the level unchanged here.
// RULE_06: Interrupt-enable instruction writes 10, level 0.
// RULE_07: Interrupt-disable writes 11; trap also leaves both bits set.
// RULE_08: Branch-if-masked taken at 11, its complement taken otherwise.
// RULE_09: Level set by an instruction holds until return or another such instruction.
// RULE_10: Four 8-bit priority registers reset to ones, one pair per vector.
// RULE_11: Vector n uses pair n, four pairs per register, pair 0 lowest.
// RULE_12: Upper four bits of the fourth priority register read as ones.
// RULE_13: Top-level pin pair is read/write but ignored by arbitration.
// RULE_14: Writing pattern 10 to a pair leaves that pair unchanged.
// RULE_15: Reset, trap and top-level pin entries set both level bits.
// RULE_16: Raised level re-enters a still-pending vector, else waits for next request.
// RULE_17: Hardware order reset, trap, pin, sources 1-13; vectors step down by two.
// RULE_18: Vector 2 shared by ext irq 0 and auto wake-up, 3 by ext irq 1 and detector.
// RULE_19: Only wake-capable sources leave halt.
// RULE_20: Time-base source wakes from active halt only.
// RULE_21: Highest software level first, ties by hardware priority.
// RULE_22: Maskable served only if its level exceeds the current one, else stays pending.
// RULE_23: Entry pushes PC, X, A, CC before loading the vector.
// RULE_24: Return restores the level from the stacked condition code.
// RULE_25: Patterns are decoded to ordered levels 0..3 before comparing.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module nipc_top (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [nipc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    input wire logic [nipc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    input wire logic [nipc_pkg::NSRC-1:0] src_req, // Pending requests, bit 0 is top-level pin
    input wire logic awu_req, // Auto wake-up from halt request
    input wire logic avd_req, // Auxiliary voltage detector request
    input wire logic active_halt, // Halt is the active-halt flavour
    input wire nipc_pkg::nipc_cpu_req_t cpu_req, // Instruction events from the core
    output nipc_pkg::nipc_entry_t entry, // Entry sequencing towards the core
    output logic [7:0] cc_level_bits, // Level bits placed in a condition code byte
    output logic branch_if_masked, // Masked-branch condition
    output logic branch_if_unmasked // Unmasked-branch condition
);
    import nipc_pkg::*;

    typedef enum logic [1:0] {ST_RESET_VEC, ST_IDLE, ST_PUSH, ST_VEC} nipc_state_t;

    nipc_state_t state_q;
    logic [1:0] lvl_q;
    logic [2*NSRC-1:0] prio_q;
    logic in_halt_q;
    logic [1:0] push_cnt_q;
    logic [3:0] tgt_num_q;
    logic [1:0] tgt_pair_q;
    logic tgt_nm_q;
    logic [15:0] vec_addr_q;

    function automatic logic [1:0] dec_lvl(input logic [1:0] pat);
        unique case (pat)
            PAT_LVL0: dec_lvl = 2'd0; // RULE_02
            PAT_LVL1: dec_lvl = 2'd1;
            PAT_LVL2: dec_lvl = 2'd2;
            PAT_LVL3: dec_lvl = 2'd3;
        endcase
    endfunction

    // Decoded levels
    logic [1:0] cur_lvl;
    logic [1:0] plvl [NSRC];
    assign cur_lvl = dec_lvl(lvl_q); // RULE_25
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_dec
            assign plvl[gi] = dec_lvl(prio_q[2*gi+1:2*gi]); // RULE_11 RULE_25
        end
    endgenerate

    // Request gathering
    logic [NSRC-1:0] all_req;
    logic [NSRC-1:0] wake_req;
    logic [NSRC-1:0] req_eff;
    always_comb begin
        all_req = src_req;
        all_req[2] = src_req[2] | awu_req; // RULE_18
        all_req[3] = src_req[3] | avd_req; // RULE_18
        wake_req = all_req & WAKE_MASK; // RULE_19
        wake_req[1] = src_req[1] & active_halt; // RULE_20
        wake_req[3] = src_req[3]; // RULE_19
        req_eff = in_halt_q ? wake_req : all_req;
    end

    // Arbitration: scan low to high hardware priority so that ties go to the lower number
    logic found;
    logic [3:0] win_num;
    logic [1:0] win_lvl;
    always_comb begin
        found = 1'b0;
        win_num = 4'h0;
        win_lvl = 2'd0;
        for (int i = NSRC - 1; i >= 1; i--) begin
            if (req_eff[i] && plvl[i] > cur_lvl && (!found || plvl[i] >= win_lvl)) begin // RULE_21 RULE_22
                found = 1'b1;
                win_num = 4'(i);
                win_lvl = plvl[i];
            end
        end
        // Pin source ignores its own pair and the current level
        if (req_eff[0]) begin // RULE_03 RULE_13
            found = 1'b1;
            win_num = 4'h0;
        end
    end

    logic op_take;
    logic trap_take;
    logic irq_take;
    assign op_take = (state_q == ST_IDLE) && cpu_req.op_valid;
    assign trap_take = op_take && cpu_req.op == OP_TRAP;
    assign irq_take = (state_q == ST_IDLE) && !cpu_req.op_valid && cpu_req.boundary && found;

    // Entry sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RESET_VEC;
            push_cnt_q <= 2'd0;
        end else begin
            unique case (state_q)
                ST_RESET_VEC: state_q <= ST_IDLE;
                ST_IDLE: begin
                    if (trap_take || irq_take) begin
                        state_q <= ST_PUSH; // RULE_23
                        push_cnt_q <= 2'd0;
                    end
                end
                ST_PUSH: begin
                    push_cnt_q <= push_cnt_q + 2'd1;
                    if (push_cnt_q == PUSH_LAST) begin
                        state_q <= ST_VEC;
                    end
                end
                ST_VEC: state_q <= ST_IDLE;
            endcase
        end
    end

    // Target capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_num_q <= NUM_RESET;
            tgt_pair_q <= LVL_RST;
            tgt_nm_q <= 1'b1;
            vec_addr_q <= VEC_RESET; // RULE_17
        end else if (trap_take) begin
            tgt_num_q <= NUM_TRAP;
            tgt_nm_q <= 1'b1;
            vec_addr_q <= VEC_TRAP; // RULE_17
        end else if (irq_take) begin
            tgt_num_q <= win_num;
            tgt_pair_q <= prio_q[2*win_num+:2]; // RULE_04
            tgt_nm_q <= (win_num == 4'h0);
            vec_addr_q <= VEC_SRC0 - {11'h000, win_num, 1'b0}; // RULE_17
        end
    end

    // Current level; a raised pair re-enters through the comparator while still pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q <= LVL_RST; // RULE_15
        end else if (state_q == ST_VEC) begin
            lvl_q <= tgt_nm_q ? PAT_LVL3 : tgt_pair_q; // RULE_04 RULE_15 RULE_16
        end else if (op_take) begin
            unique case (cpu_req.op)
                OP_RIM, OP_HALT, OP_WFI: lvl_q <= PAT_LVL0; // RULE_05 RULE_06 RULE_09
                OP_SIM: lvl_q <= PAT_LVL3; // RULE_07 RULE_09
                OP_IRQ_RETURN_INSTR, OP_POPCC: lvl_q <= {cpu_req.cc_in[CC_LVL_HI_POS],
                    cpu_req.cc_in[CC_LVL_LO_POS]}; // RULE_24 RULE_09
                default: lvl_q <= lvl_q;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_halt_q <= 1'b0;
        end else if (irq_take) begin
            in_halt_q <= 1'b0;
        end else if (op_take && cpu_req.op == OP_HALT) begin
            in_halt_q <= 1'b1;
        end
    end

    always_comb begin
        cc_level_bits = 8'h00;
        cc_level_bits[CC_LVL_HI_POS] = lvl_q[1]; // RULE_01
        cc_level_bits[CC_LVL_LO_POS] = lvl_q[0]; // RULE_01
    end
    assign branch_if_masked = (lvl_q == PAT_LVL3); // RULE_08
    assign branch_if_unmasked = (lvl_q != PAT_LVL3); // RULE_08

    assign entry.push_valid = (state_q == ST_PUSH);
    assign entry.push_sel = push_cnt_q;
    assign entry.vec_valid = (state_q == ST_VEC) || (state_q == ST_RESET_VEC);
    assign entry.vec_addr = vec_addr_q;
    assign entry.vec_num = tgt_num_q;
    assign entry.wake = in_halt_q && found; // RULE_19

    // AXI4-Lite slave; write address and data may arrive in either order
    logic aw_got_q;
    logic w_got_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0] wbyte_q;
    logic wen_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [ADDR_W-1:0] raddr_q;
    logic do_write;
    logic wmapped;

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign wmapped = waddr_q[1:0] == 2'b00 && waddr_q <= OFF_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            waddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q <= 1'b0;
            wbyte_q <= 8'h00;
            wen_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wen_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_got_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wmapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Priority storage, one pair per vector
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_pair
            localparam logic [ADDR_W-1:0] POFF = ADDR_W'(4 * (gi / 4));
            localparam int SH = 2 * (gi % 4);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    prio_q[2*gi+:2] <= PRIO_RST[SH+:2]; // RULE_10
                end else if (do_write && wen_q && waddr_q == POFF &&
                             wbyte_q[SH+:2] != PAT_LVL0) begin // RULE_14
                    prio_q[2*gi+:2] <= wbyte_q[SH+:2]; // RULE_11 RULE_13
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            raddr_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            raddr_q <= s_axi_araddr;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            unique case (s_axi_araddr)
                OFF_PRIO0: rdata_q[7:0] <= prio_q[7:0];
                OFF_PRIO1: rdata_q[7:0] <= prio_q[15:8];
                OFF_PRIO2: rdata_q[7:0] <= prio_q[23:16];
                OFF_PRIO3: rdata_q[7:0] <= {PRIO3_RO_ONES, prio_q[27:24]}; // RULE_12
                OFF_STATUS: begin
                    rdata_q[7:0] <= cc_level_bits;
                    rdata_q[ST_HALT_POS] <= in_halt_q;
                    rdata_q[ST_BUSY_POS] <= (state_q != ST_IDLE);
                    rdata_q[ST_VNUM_POS+:4] <= tgt_num_q;
                end
                default: rresp_q <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence push_phase;
        entry.push_valid [*4];
    endsequence
    sequence vec_phase;
        entry.vec_valid && !entry.push_valid;
    endsequence

    rim_level_a: assert property (op_take && cpu_req.op == OP_RIM |=> lvl_q == 2'b10) // RULE_06
        else $error("enable instruction did not select level 0");
    sim_level_a: assert property (op_take && cpu_req.op == OP_SIM |=> branch_if_masked) // RULE_07
        else $error("disable instruction did not select level 3");
    branch_cond_a: assert property (branch_if_masked == // RULE_08
        (cc_level_bits[5] && cc_level_bits[3]) && branch_if_unmasked != branch_if_masked)
        else $error("masked branch condition wrong");
    entry_seq_a: assert property (trap_take || irq_take |=> push_phase ##1 vec_phase) // RULE_23
        else $error("entry did not push four items then load the vector");
    mask_load_a: assert property (state_q == ST_VEC && !tgt_nm_q // RULE_04
        |=> lvl_q == 2'($past(prio_q, 6) >> (2 * tgt_num_q)))
        else $error("entry level differs from priority pair");
    nm_level_a: assert property (state_q == ST_VEC && tgt_nm_q |=> lvl_q == 2'b11) // RULE_15
        else $error("non-maskable entry did not set level 3");
    level_gate_a: assert property (irq_take && win_num != 4'h0 |-> plvl[win_num] > cur_lvl) // RULE_22
        else $error("maskable taken without exceeding current level");
    halt_wake_a: assert property (irq_take && in_halt_q |-> WAKE_MASK[win_num] // RULE_19
        && (win_num != 4'h1 || active_halt))
        else $error("halt left by a source unable to wake");
    pair_keep_a: assert property (do_write && wen_q && waddr_q == OFF_PRIO0 && // RULE_14
        wbyte_q[1:0] == 2'b10 |=> $stable(prio_q[1:0]))
        else $error("level 0 pattern was stored");
    prio3_ro_a: assert property (s_axi_arvalid && s_axi_arready && // RULE_12
        s_axi_araddr == OFF_PRIO3 |=> s_axi_rdata[7:4] == 4'hf)
        else $error("read-only upper bits not ones");
    vec_addr_a: assert property (state_q == ST_VEC && tgt_num_q < 4'he // RULE_17
        |-> entry.vec_addr == 16'hfffa - {11'h000, tgt_num_q, 1'b0})
        else $error("vector address out of order");
endmodule

//--- verification/nipc_core_model.sv
// Core model on the far side: issues instruction events, stacks the level on entry.
// Assumes the bench commands one instruction at a time, only while no entry runs.
`timescale 1ns/10ps
module nipc_core_model (
    input logic aclk, // Clock
    input logic aresetn, // Reset, active low
    input nipc_pkg::nipc_entry_t entry, // Entry sequencing from the block
    input logic [7:0] cc_level_bits, // Current level bits
    input logic cmd_valid, // Bench asks for an instruction
    input nipc_pkg::nipc_op_t cmd_op, // Instruction kind
    input logic [7:0] cmd_cc, // Byte for a pop of the condition code
    input logic bnd, // Core sits at an instruction end
    output nipc_pkg::nipc_cpu_req_t cpu_req, // Events to the block
    output logic [2:0] pushes, // Stack writes seen in the last entry
    output logic push_ok, // Stack order kept so far
    output logic [7:0] vec_cnt // Vector loads seen
);
    import nipc_pkg::*;
    logic [7:0] stk_q [0:3];
    logic [1:0] sp_q;
    logic [2:0] cnt_q;
    always_comb begin
        cpu_req.op_valid = cmd_valid;
        cpu_req.op = cmd_op;
        // Return hands back the byte on top of the stack
        cpu_req.cc_in = (cmd_op == OP_IRQ_RETURN_INSTR) ? stk_q[sp_q - 2'd1] : cmd_cc;
        cpu_req.boundary = bnd;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_q <= 2'd0;
            cnt_q <= 3'd0;
            pushes <= 3'd0;
            push_ok <= 1'b1;
            vec_cnt <= 8'h00;
        end else begin
            if (entry.push_valid) begin
                cnt_q <= cnt_q + 3'd1;
                if (entry.push_sel != cnt_q[1:0]) push_ok <= 1'b0;
                if (entry.push_sel == PUSH_LAST) begin
                    stk_q[sp_q] <= cc_level_bits;
                    sp_q <= sp_q + 2'd1;
                end
            end
            if (entry.vec_valid) begin
                pushes <= cnt_q;
                cnt_q <= 3'd0;
                vec_cnt <= vec_cnt + 8'h01;
            end
            if (cmd_valid && cmd_op == OP_IRQ_RETURN_INSTR) sp_q <= sp_q - 2'd1;
        end
    end
endmodule

//--- verification/nipc_top_bench.sv
// Self-checking bench for the interrupt priority controller.
// Assumes the core model drives cpu_req; the bench plays AXI master and peripherals.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module nipc_top_bench;
    import nipc_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, cmd_cc = 0, n, vec_cnt, cc_level_bits;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [13:0] src_req = 0;
    logic awu_req = 0, avd_req = 0, active_halt = 0, cmd_valid = 0, bnd = 0, push_ok;
    logic awready, wready, bvalid, arready, rvalid, masked, unmasked;
    logic [1:0] bresp, rresp;
    logic [2:0] pushes;
    nipc_op_t cmd_op = OP_NONE;
    nipc_cpu_req_t cpu_req;
    nipc_entry_t entry;
    int err_count = 0, n_checks = 0, cyc = 0;
    typedef struct {nipc_op_t op; logic [7:0] cc; logic [7:0] ecc; logic m;} nipc_row_t;
    nipc_row_t rows [8] = '{'{OP_SIM, 8'h00, 8'h28, 1'b1}, '{OP_RIM, 8'h00, 8'h20, 1'b0},
        '{OP_POPCC, 8'h08, 8'h08, 1'b0}, '{OP_PUSHCC, 8'h00, 8'h08, 1'b0},
        '{OP_POPCC, 8'h00, 8'h00, 1'b0}, '{OP_WFI, 8'h00, 8'h20, 1'b0},
        '{OP_POPCC, 8'h28, 8'h28, 1'b1}, '{OP_RIM, 8'h00, 8'h20, 1'b0}};
    // Halt rows: requests, wake-up, detector, active halt, expected wake
    logic [17:0] hrows [6] = '{{14'h0200, 4'b0000}, {14'h0100, 4'b0001},
        {14'h0002, 4'b0000}, {14'h0002, 4'b0011}, {14'h0000, 4'b0100}, {14'h0000, 4'b1001}};
    always #5 aclk = ~aclk;
    nipc_top u_nipc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .src_req(src_req), .awu_req(awu_req), .avd_req(avd_req),
        .active_halt(active_halt), .cpu_req(cpu_req), .entry(entry),
        .cc_level_bits(cc_level_bits), .branch_if_masked(masked),
        .branch_if_unmasked(unmasked));
    nipc_core_model u_nipc_core_model (.aclk(aclk), .aresetn(aresetn), .entry(entry),
        .cc_level_bits(cc_level_bits), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_cc(cmd_cc), .bnd(bnd), .cpu_req(cpu_req), .pushes(pushes),
        .push_ok(push_ok), .vec_cnt(vec_cnt));
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Ready is sampled at the falling edge, so the handshake seen is the one at the next rise
    task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) break;
        end
        bready <= 1'b0;
        `CHK("bresp", er, r)
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ah = arvalid & arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rh) break;
        end
        rready <= 1'b0;
        `CHK("rdata", ed, d)
        `CHK("rresp", er, r)
    endtask
    task do_op(input nipc_op_t op, input logic [7:0] cc);
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_cc <= cc;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    task wait_vec(input logic [15:0] va, input logic [3:0] vn, input logic [7:0] ec);
        do begin
            @(posedge aclk);
            #1;
        end while (entry.vec_valid !== 1'b1);
        `CHK("vec_addr", va, entry.vec_addr)
        `CHK("vec_num", vn, entry.vec_num)
        @(posedge aclk);
        #1;
        `CHK("pushes", 3'd4, pushes)
        `CHK("push_order", 1'b1, push_ok)
        `CHK("entry_cc", ec, cc_level_bits)
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK("rst_vec", 1'b1, entry.vec_valid)
        `CHK("rst_addr", VEC_RESET, entry.vec_addr)
        `CHK("rst_num", NUM_RESET, entry.vec_num)
        `CHK("rst_cc", 8'h28, cc_level_bits)
        rd_chk(OFF_STATUS, 32'h0000_f028, RESP_OKAY);
        rd_chk(OFF_PRIO0, 32'h0000_00ff, RESP_OKAY);
        rd_chk(OFF_PRIO2, 32'h0000_00ff, RESP_OKAY);
        wstrb <= 4'h0;
        wr_chk(OFF_PRIO2, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFF_PRIO2, 32'h0000_00ff, RESP_OKAY);
        wstrb <= 4'hf;
        wr_chk(OFF_PRIO3, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFF_PRIO3, 32'h0000_00f0, RESP_OKAY);
        wr_chk(8'h14, 32'h0000_0000, RESP_SLVERR);
        rd_chk(8'h14, 32'h0000_0000, RESP_SLVERR);
        wr_chk(OFF_PRIO1, 32'h0000_00cf, RESP_OKAY);
        wr_chk(OFF_PRIO1, 32'h0000_0064, RESP_OKAY);
        rd_chk(OFF_PRIO1, 32'h0000_0044, RESP_OKAY);
        wr_chk(OFF_PRIO0, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFF_PRIO0, 32'h0000_0000, RESP_OKAY);
        $display("register test done");
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].cc);
            `CHK("op_cc", rows[i].ecc, cc_level_bits)
            `CHK("masked", rows[i].m, masked)
            `CHK("unmasked", ~rows[i].m, unmasked)
        end
        $display("instruction test done");
        @(posedge aclk);
        bnd <= 1'b1;
        src_req <= 14'h0020;
        wait_vec(16'hfff0, 4'h5, 8'h08);
        @(posedge aclk);
        src_req <= 14'h0070;
        wait_vec(16'hfff2, 4'h4, 8'h00);
        n = vec_cnt;
        repeat (10) @(posedge aclk);
        #1;
        `CHK("still_pending", n, vec_cnt)
        src_req <= 14'h0020;
        do_op(OP_IRQ_RETURN_INSTR, 8'h00);
        `CHK("irq_return_instr_cc", 8'h08, cc_level_bits)
        // Raising the running vector's level while it is still pending re-enters it
        wr_chk(OFF_PRIO1, 32'h0000_0040, RESP_OKAY);
        wait_vec(16'hfff0, 4'h5, 8'h00);
        src_req <= 14'h0000;
        do_op(OP_IRQ_RETURN_INSTR, 8'h00);
        `CHK("irq_return_instr_cc", 8'h08, cc_level_bits)
        do_op(OP_IRQ_RETURN_INSTR, 8'h00);
        `CHK("irq_return_instr_cc", 8'h20, cc_level_bits)
        $display("nesting test done");
        do_op(OP_SIM, 8'h00);
        do_op(OP_TRAP, 8'h00);
        wait_vec(VEC_TRAP, NUM_TRAP, 8'h28);
        do_op(OP_IRQ_RETURN_INSTR, 8'h00);
        src_req <= 14'h0001;
        wait_vec(VEC_SRC0, 4'h0, 8'h28);
        src_req <= 14'h0000;
        do_op(OP_IRQ_RETURN_INSTR, 8'h00);
        `CHK("irq_return_instr_cc", 8'h28, cc_level_bits)
        $display("non-maskable test done");
        bnd <= 1'b0;
        do_op(OP_HALT, 8'h00);
        `CHK("halt_cc", 8'h20, cc_level_bits)
        foreach (hrows[i]) begin
            @(posedge aclk);
            {src_req, awu_req, avd_req, active_halt} <= hrows[i][17:1];
            #1;
            `CHK("wake", hrows[i][0], entry.wake)
        end
        @(posedge aclk);
        {src_req, awu_req, avd_req, bnd} <= {14'h0100, 3'b001};
        wait_vec(16'hffea, 4'h8, 8'h28);
        $display("halt test done");
        report_and_stop();
    end
endmodule
